// ==== rtl/adc_chsel_cfg.svh ====
// constants for the input configuration and channel select block
// assumes inclusion from the design module only
`ifndef ADC_CHSEL_CFG_SVH
`define ADC_CHSEL_CFG_SVH
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_LAST 12'h008
`define CTRL_ADDR_LO 0
`define CTRL_ADDR_HI 1
`define CTRL_CFG_A 2
`define CTRL_CFG_B 3
`define CTRL_SEQ_A 4
`define CTRL_SEQ_B 5
`define CTRL_RESET 32'h0000_0000
`define FULL_CODE_12 13'h1000
`define FULL_CODE_10 13'h0400
`endif

// ==== rtl/adc_chsel_pkg.sv ====
// types for the input configuration and channel select block
// assumes the constants header sits in the same folder
package adc_chsel_pkg;
   typedef enum logic [1:0] {
      CFG_SINGLE,
      CFG_DIFF,
      CFG_PSEUDO,
      CFG_UNUSED
   } input_cfg_t;
   typedef enum logic [1:0] {
      SEQ_NORMAL,
      SEQ_BAD_A,
      SEQ_BAD_B,
      SEQ_CONSEC
   } seq_mode_t;
endpackage

// ==== rtl/adc_chsel.sv ====
// input configuration decode and per-conversion channel selection
// assumes an apb master on mclk_in and conversion_start_n from a pin
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "adc_chsel_cfg.svh"

// Functional notes
// - cfg bits 00: four single-ended inputs, each against analog ground
// - cfg bits a=0 b=1: two fully differential pairs
// - cfg bits a=1 b=0: two pseudo-differential pairs, negative is pseudo ground
// - seq bits 00: normal multichannel, no automatic stepping
// - host writes address bits first; device muxes that for next conversion
// - each control write sets the channel of the next conversion
// - any channel or allowed pair may be picked in any order
// - differential span maps onto 0..4096 (12 bit) or 0..1024 (10 bit)
// - seq bits 11: step from channel 0 to address, then wrap
// - sequence runs until the next control write, which restarts it at channel 0
// - falling conversion-start edge samples the selected channel
module adc_chsel #(
   parameter int RES_BITS = 12
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic conversion_start_n,
   output logic sample_out,
   output logic [1:0] pos_analog_input_out,
   output logic [1:0] neg_analog_input_out,
   output logic neg_is_ground_out,
   output logic paired_out,
   output logic [12:0] full_code_out
);
   initial begin
      if (RES_BITS != 12 && RES_BITS != 10) begin
         $error("RES_BITS must be 10 or 12");
      end
   end

   logic [5:0] ctrl_q;
   logic [1:0] seq_chan_q;
   logic [1:0] last_chan_q;
   logic [2:0] conv_sync_q;
   logic sample_q;
   logic [1:0] pos_q;
   logic [1:0] neg_q;
   logic gnd_q;
   logic paired_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [12:0] full_code_q;

   wire logic [1:0] addr_w = ctrl_q[`CTRL_ADDR_HI:`CTRL_ADDR_LO];
   wire adc_chsel_pkg::input_cfg_t cfg_w =
      adc_chsel_pkg::input_cfg_t'({ctrl_q[`CTRL_CFG_A], ctrl_q[`CTRL_CFG_B]});
   wire adc_chsel_pkg::seq_mode_t seq_w =
      adc_chsel_pkg::seq_mode_t'({ctrl_q[`CTRL_SEQ_A], ctrl_q[`CTRL_SEQ_B]});
   wire logic access_w = psel_in && penable_in && !pready_q;
   wire logic hit_ctrl_w = paddr_in == `OFS_CTRL;
   wire logic hit_stat_w = paddr_in == `OFS_STATUS;
   wire logic hit_last_w = paddr_in == `OFS_LAST;
   wire logic mapped_w = hit_ctrl_w || hit_stat_w || hit_last_w;
   wire logic ctrl_wr_w = access_w && pwrite_in && hit_ctrl_w;
   // second and third synchroniser stages give the falling edge
   wire logic fall_w = conv_sync_q[2] && !conv_sync_q[1];
   wire logic consec_w = seq_w == adc_chsel_pkg::SEQ_CONSEC;
   // channel that this conversion uses
   wire logic [1:0] use_chan_w = consec_w ? seq_chan_q : addr_w;
   wire logic paired_w = cfg_w == adc_chsel_pkg::CFG_DIFF || cfg_w == adc_chsel_pkg::CFG_PSEUDO;
   // paired modes: bit 0 of use_chan_w (address or sequence step) picks pair, positive is the even input
   wire logic [1:0] pos_w = paired_w ? {use_chan_w[0], 1'b0} : use_chan_w;
   wire logic [1:0] neg_w = paired_w ? {use_chan_w[0], 1'b1} : 2'h0;
   wire logic gnd_w = !paired_w;
   // in paired modes the last step is the pair index
   wire logic [1:0] seq_end_w = paired_w ? {1'b0, addr_w[0]} : addr_w;
   wire logic [1:0] seq_next_w = (seq_chan_q >= seq_end_w) ? 2'h0 : seq_chan_q + 2'h1;
   wire logic [31:0] rd_w = hit_ctrl_w ? {26'h0, ctrl_q} :
      hit_stat_w ? {28'h0, seq_chan_q, paired_q, gnd_q} :
      hit_last_w ? {28'h0, neg_q, pos_q} : 32'h0;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         conv_sync_q <= 3'h7;
      end else if (clk_en_in) begin
         conv_sync_q <= {conv_sync_q[1:0], conversion_start_n};
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= 6'(`CTRL_RESET);
         seq_chan_q <= 2'h0;
      end else if (clk_en_in) begin
         if (ctrl_wr_w) begin
            ctrl_q <= pwdata_in[5:0];
            seq_chan_q <= 2'h0;
         end else if (fall_w && consec_w) begin
            seq_chan_q <= seq_next_w;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         sample_q <= 1'b0;
         pos_q <= 2'h0;
         neg_q <= 2'h0;
         gnd_q <= 1'b1;
         paired_q <= 1'b0;
         last_chan_q <= 2'h0;
      end else if (clk_en_in) begin
         sample_q <= fall_w;
         if (fall_w) begin
            pos_q <= pos_w;
            neg_q <= neg_w;
            gnd_q <= gnd_w;
            paired_q <= paired_w;
            last_chan_q <= use_chan_w;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else if (clk_en_in) begin
         pready_q <= access_w;
         pslverr_q <= access_w && !mapped_w;
         prdata_q <= (access_w && !pwrite_in) ? rd_w : 32'h0;
      end
   end

   // full-scale code count is fixed by the resolution and loaded at reset
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         full_code_q <= (RES_BITS == 12) ? `FULL_CODE_12 : `FULL_CODE_10;
      end
   end

   assign prdata_out = prdata_q;
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign sample_out = sample_q;
   assign pos_analog_input_out = pos_q;
   assign neg_analog_input_out = neg_q;
   assign neg_is_ground_out = gnd_q;
   assign paired_out = paired_q;
   // differential full-scale code count for the chosen resolution
   assign full_code_out = full_code_q;

   a_sample_edge: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && conv_sync_q[2] && !conv_sync_q[1] |=> sample_out)
      else $error("sample missing after falling start");
   a_single_gnd: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && cfg_w == adc_chsel_pkg::CFG_SINGLE |=> neg_is_ground_out)
      else $error("single-ended not ground referred");
   a_diff_pair: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && cfg_w == adc_chsel_pkg::CFG_DIFF
      |=> paired_out && neg_analog_input_out[0])
      else $error("differential pair wrong");
   a_pseudo_pair: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && cfg_w == adc_chsel_pkg::CFG_PSEUDO
      |=> !neg_is_ground_out && neg_analog_input_out == pos_analog_input_out + 2'h1)
      else $error("pseudo pair wrong");
   a_normal_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && seq_w == adc_chsel_pkg::SEQ_NORMAL
      |=> last_chan_q == $past(addr_w))
      else $error("normal mode channel not the written one");
   a_write_chan: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && ctrl_wr_w |=> ctrl_q == $past(pwdata_in[5:0]))
      else $error("control write lost");
   a_seq_restart: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && ctrl_wr_w |=> seq_chan_q == 2'h0)
      else $error("sequence not restarted");
   a_seq_wrap: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && consec_w && !ctrl_wr_w && seq_chan_q >= seq_end_w
      |=> seq_chan_q == 2'h0)
      else $error("sequence did not wrap");
   a_pair_index: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && paired_w |=> pos_analog_input_out[0] == 1'b0)
      else $error("pair index wrong");
   a_full_code: assert property (@(posedge mclk_in) disable iff (rst_in)
      full_code_out == ((RES_BITS == 12) ? `FULL_CODE_12 : `FULL_CODE_10))
      else $error("full code wrong");

   // bus answer checks
   a_apb_answer: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && access_w |=> pready_out)
      else $error("no ready after access");

   a_ready_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && pready_out |=> !pready_out)
      else $error("ready longer than one cycle");

   a_slverr_map: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && access_w && !mapped_w |=> pslverr_out)
      else $error("unmapped access without error");

   a_slverr_ready: assert property (@(posedge mclk_in) disable iff (rst_in)
      pslverr_out |-> pready_out)
      else $error("error without ready");

   a_rdata_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && !access_w |=> prdata_out == 32'h0)
      else $error("read data not zero outside a read");

   a_read_ctrl: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && access_w && !pwrite_in && hit_ctrl_w
      |=> prdata_out == {26'h0, $past(ctrl_q)})
      else $error("control readback wrong");

   a_bad_write: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && access_w && pwrite_in && !hit_ctrl_w |=> $stable(ctrl_q))
      else $error("write outside control changed it");

   a_freeze_all: assert property (@(posedge mclk_in) disable iff (rst_in)
      !clk_en_in |=> $stable(ctrl_q) && $stable(sample_out) && $stable(pready_out))
      else $error("state moved while enable low");

   // conversion and mux checks
   a_no_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && !fall_w |=> !sample_out)
      else $error("sample without falling start");

   a_mux_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && !fall_w |=> $stable(pos_analog_input_out) && $stable(neg_analog_input_out))
      else $error("mux moved between conversions");

   a_single_neg: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && !paired_w |=> neg_analog_input_out == 2'h0)
      else $error("single-ended negative index not zero");

   a_single_pos: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && !paired_w |=> pos_analog_input_out == $past(use_chan_w))
      else $error("single-ended channel wrong");

   a_pair_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w |=> paired_out == $past(paired_w))
      else $error("paired flag wrong");

   a_diff_float: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && paired_w |=> !neg_is_ground_out)
      else $error("paired mode tied to ground");

   // sequencer checks
   a_seq_step: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && fall_w && consec_w && !ctrl_wr_w && seq_chan_q < seq_end_w
      |=> seq_chan_q == $past(seq_chan_q) + 2'h1)
      else $error("sequence did not step");

   a_seq_still: assert property (@(posedge mclk_in) disable iff (rst_in)
      clk_en_in && !consec_w && !ctrl_wr_w |=> $stable(seq_chan_q))
      else $error("step moved in normal mode");

   c_pseudo_conv: cover property (@(posedge mclk_in) disable iff (rst_in)
      fall_w && cfg_w == adc_chsel_pkg::CFG_PSEUDO);
   c_unmapped: cover property (@(posedge mclk_in) disable iff (rst_in)
      access_w && !mapped_w);
   c_consec_wrap: cover property (@(posedge mclk_in) disable iff (rst_in)
      fall_w && consec_w && seq_chan_q == 2'h3);
   c_diff_conv: cover property (@(posedge mclk_in) disable iff (rst_in)
      fall_w && cfg_w == adc_chsel_pkg::CFG_DIFF);
   c_write_then_conv: cover property (@(posedge mclk_in) disable iff (rst_in)
      ctrl_wr_w ##[1:20] fall_w);
endmodule

// ==== testbench/conv_host.sv ====
// host side model: drives the conversion start pin
// assumes go_in is a one-cycle request on mclk_in
`timescale 1ns/1ns
module conv_host (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic go_in,
   output logic conversion_start_n
);
   logic [3:0] cnt_q;
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 4'h0;
      end else if (go_in && cnt_q == 4'h0) begin
         cnt_q <= 4'h9;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   // low 4 cycles then high 5, one falling edge per request
   assign conversion_start_n = !(cnt_q > 4'h5);
endmodule

// ==== testbench/adc_chsel_tb_top.sv ====
// bench for channel select: apb host tasks, expected queue, output watcher
// assumes conv_host model and the design with 12-bit resolution
`timescale 1ns/1ns
module adc_chsel_tb_top;
   logic mclk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, go = 0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd, seed = 32'hF986;
   logic pready_out, pslverr_out, se, conversion_start_n, sample_out, neg_is_ground_out;
   logic paired_out;
   logic [1:0] pos_analog_input_out, neg_analog_input_out, a, m;
   logic [12:0] full_code_out;
   logic [5:0] expq[$];
   int err_total = 0, total_checks = 0;
   always #5 mclk_in = ~mclk_in;
   adc_chsel #(.RES_BITS(12)) adc_chsel_inst (.mclk_in(mclk_in), .rst_in(rst_in),
      .clk_en_in(1'b1), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out),
      .conversion_start_n(conversion_start_n), .sample_out(sample_out),
      .pos_analog_input_out(pos_analog_input_out),
      .neg_analog_input_out(neg_analog_input_out), .neg_is_ground_out(neg_is_ground_out),
      .paired_out(paired_out), .full_code_out(full_code_out));
   conv_host conv_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go),
      .conversion_start_n(conversion_start_n));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         err_total++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      int n;
      @(posedge mclk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         results();
      end
      rd = prdata_out;
      se = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // note the expected mux state, start one conversion, wait until it is seen
   task automatic conv(input logic [5:0] e);
      int n;
      expq.push_back(e);
      @(posedge mclk_in);
      go <= 1'b1;
      @(posedge mclk_in);
      go <= 1'b0;
      for (n = 0; n < 40 && expq.size() > 0; n++) @(posedge mclk_in);
      if (expq.size() > 0) begin
         err_total++;
         results();
      end
      repeat (6) @(posedge mclk_in);
   endtask
   always @(posedge mclk_in) begin
      if (sample_out === 1'b1) begin
         if (expq.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            check({pos_analog_input_out, neg_analog_input_out, neg_is_ground_out,
               paired_out}, expq.pop_front());
         end
      end
   end
   initial begin
      repeat (5) @(posedge mclk_in);
      rst_in <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h0);
      check(full_code_out, 32'h1000);
      $display("test reset done");
      // single, differential and pseudo-differential configurations with random addresses, one conversion after each write
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         a = seed[1:0];
         m = 2'(i % 3);
         apb(1'b1, 12'h000, {28'h0, m, a});
         if (m == 2'h0) conv({a, 2'h0, 2'b10});
         else conv({a[0], 1'b0, a[0], 1'b1, 2'b01});
      end
      $display("test normal mode done");
      apb(1'b1, 12'h000, 32'h32);
      for (int i = 0; i < 4; i++) conv({i[1:0] % 2'h3, 2'h0, 2'b10});
      apb(1'b1, 12'h000, 32'h3);
      conv({2'h3, 2'h0, 2'b10});
      $display("test sequence done");
      apb(1'b0, 12'h0F0, 32'h0);
      check({se, rd}, {1'b1, 32'h0});
      $display("test unmapped done");
      results();
   end
endmodule
